// ===== include/phy_status_map.svh
`ifndef PHY_STATUS_MAP_SVH
`define PHY_STATUS_MAP_SVH

// management register addresses
`define REG_STATUS 5'h01
`define REG_ID_UPPER 5'h02
`define REG_ID_LOWER 5'h03

// management frame figures
`define PREAMBLE_ONES 6'h20
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define ADDR_BITS_LAST 5'h09
`define DATA_BITS_LAST 5'h0F

// fixed fields of the status word, high bit to low
`define CAP_T4 1'h0
`define CAP_SPEEDS 4'hF
`define STATUS_RSVD 4'h0
`define PREAMBLE_SUPP 1'h0
`define AN_ABLE 1'h1
`define EXT_CAP 1'h1

// status word bit positions
`define BIT_AN_DONE 5
`define BIT_FAR_FAULT 4
`define BIT_LINK 2
`define BIT_JABBER 1

// reset values
`define LATCH_RESET 1'h0
`define WORD_RESET 16'h0000

`endif

// ===== include/phy_regs_pkg.sv
package phy_regs_pkg;

  typedef enum logic [2:0] {
    ST_PRE   = 3'b000,
    ST_START = 3'b001,
    ST_OP    = 3'b010,
    ST_ADDR  = 3'b011,
    ST_TA    = 3'b100,
    ST_DATA  = 3'b101
  } mgmt_state_t;

  typedef struct packed {
    logic an_done;
    logic far_end_fault_flag;
    logic link_up;
    logic jabber;
    logic speed_100;
  } phy_events_t;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } id_pair_t;

endpackage

// ===== rtl/latch_bit.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_status_map.svh"

// one sticky status bit; LATCH_LOW picks latch-on-low behaviour
module latch_bit #(
  parameter bit LATCH_LOW = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic soft_clr,
  input wire logic level_in,
  input wire logic read_clr,
  output var logic q
);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= `LATCH_RESET;
    end else if (LATCH_LOW) begin
      // a failure in the clearing cycle still wins
      q <= level_in & (q | read_clr) & ~soft_clr;
    end else begin
      q <= level_in | (q & ~read_clr & ~soft_clr);
    end
  end

endmodule // latch_bit

`default_nettype wire

// ===== rtl/id_words.sv
`timescale 1ns/1ps
`default_nettype none

// oui[23] is the standard's bit 1, oui[0] its bit 24
module id_words #(
  parameter logic [23:0] ORG_ID = 24'h123456, // arbitrary value
  parameter logic [5:0] MODEL = 6'h01,        // arbitrary value
  parameter logic [3:0] REVISION = 4'h0       // arbitrary value
) (
  output phy_regs_pkg::id_pair_t ids
);

  // the two top oui bits are dropped
  // one driver for the whole struct: upper word then lower word
  assign ids = {ORG_ID[21:6], ORG_ID[5:0], MODEL, REVISION};

endmodule // id_words

`default_nettype wire

// ===== rtl/phy_status_and_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_status_map.svh"

module phy_status_and_id_regs #(
  parameter logic [23:0] ORG_ID = 24'h123456, // arbitrary value
  parameter logic [5:0] MODEL = 6'h01,        // arbitrary value
  parameter logic [3:0] REVISION = 4'h0       // arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic phy_soft_reset,
  input wire logic [4:0] phy_addr,
  input wire phy_regs_pkg::phy_events_t events,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  phy_regs_pkg::mgmt_state_t state;
  phy_regs_pkg::id_pair_t ids;
  logic mdc_q;
  logic mdc_rise;
  logic [5:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic op_first;
  logic op_read;
  logic [9:0] hdr;
  logic [9:0] next_hdr;
  logic addr_last;
  logic talk;
  logic talking;
  logic status_sel;
  logic [15:0] shreg;
  logic read_done;
  logic an_done_q;
  logic fault_q;
  logic link_q;
  logic jab_q;
  logic jab_event;
  logic [15:0] status_word;

  ////////////////////////////////////////////////////////////////////
  // sticky status bits, the unlatched completion bit and the identifier words

  // the detector is blind at 100 Mb/s
  assign jab_event = events.jabber & ~events.speed_100;

  latch_bit #(.LATCH_LOW(1'b0)) u_fault (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_clr(1'b0),
    .level_in(events.far_end_fault_flag),
    .read_clr(read_done),
    .q(fault_q)
  );

  latch_bit #(.LATCH_LOW(1'b1)) u_link (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_clr(phy_soft_reset),
    .level_in(events.link_up),
    .read_clr(read_done),
    .q(link_q)
  );

  latch_bit #(.LATCH_LOW(1'b0)) u_jabber (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_clr(phy_soft_reset),
    .level_in(jab_event),
    .read_clr(read_done),
    .q(jab_q)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_done_q <= 1'b0;
    end else begin
      an_done_q <= events.an_done & ~phy_soft_reset;
    end
  end

  id_words #(.ORG_ID(ORG_ID), .MODEL(MODEL), .REVISION(REVISION)) u_ids (
    .ids(ids)
  );

  ////////////////////////////////////////////////////////////////////
  // register words

  assign status_word = {`CAP_T4, `CAP_SPEEDS, `STATUS_RSVD,
                        `PREAMBLE_SUPP, an_done_q, fault_q,
                        `AN_ABLE, link_q, jab_q, `EXT_CAP};

  function automatic logic [15:0] read_word(input logic [4:0] sel);
    logic [15:0] w;
    w = `WORD_RESET;
    if (sel == `REG_STATUS) begin
      w = status_word;
    end else if (sel == `REG_ID_UPPER) begin
      w = ids.upper;
    end else if (sel == `REG_ID_LOWER) begin
      w = ids.lower;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // management frame sequencing

  assign mdc_rise = mdc & ~mdc_q;
  assign next_hdr = {hdr[8:0], mdio_in};
  assign addr_last = mdc_rise && state == phy_regs_pkg::ST_ADDR && bit_cnt == `ADDR_BITS_LAST;
  assign talk = addr_last && op_read && next_hdr[9:5] == phy_addr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // held high in reset: an idle-high mdc must not look like a rise on release
      mdc_q <= 1'b1;
    end else begin
      mdc_q <= mdc;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= phy_regs_pkg::ST_PRE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      op_first <= 1'b0;
      op_read <= 1'b0;
      hdr <= 10'h000;
    end else if (mdc_rise) begin
      unique case (state)
        phy_regs_pkg::ST_PRE: begin
          // a frame without 32 leading ones is never started
          if (mdio_in) begin
            if (pre_cnt != `PREAMBLE_ONES) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else if (pre_cnt == `PREAMBLE_ONES) begin
            state <= phy_regs_pkg::ST_START;
          end else begin
            pre_cnt <= 6'h00;
          end
        end
        phy_regs_pkg::ST_START: begin
          pre_cnt <= 6'h00;
          bit_cnt <= 5'h00;
          state <= mdio_in ? phy_regs_pkg::ST_OP : phy_regs_pkg::ST_PRE;
        end
        phy_regs_pkg::ST_OP: begin
          if (bit_cnt == 5'h00) begin
            op_first <= mdio_in;
            bit_cnt <= 5'h01;
          end else begin
            bit_cnt <= 5'h00;
            op_read <= {op_first, mdio_in} == `OP_READ;
            if ({op_first, mdio_in} == `OP_READ || {op_first, mdio_in} == `OP_WRITE) begin
              state <= phy_regs_pkg::ST_ADDR;
            end else begin
              state <= phy_regs_pkg::ST_PRE;
            end
          end
        end
        phy_regs_pkg::ST_ADDR: begin
          hdr <= next_hdr;
          if (bit_cnt == `ADDR_BITS_LAST) begin
            bit_cnt <= 5'h00;
            state <= phy_regs_pkg::ST_TA;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        phy_regs_pkg::ST_TA: begin
          if (bit_cnt == 5'h00) begin
            bit_cnt <= 5'h01;
          end else begin
            bit_cnt <= 5'h00;
            state <= phy_regs_pkg::ST_DATA;
          end
        end
        phy_regs_pkg::ST_DATA: begin
          // write data is taken and dropped: every word here is read-only
          if (bit_cnt == `DATA_BITS_LAST) begin
            bit_cnt <= 5'h00;
            state <= phy_regs_pkg::ST_PRE;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default: begin
          state <= phy_regs_pkg::ST_PRE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data drive

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      talking <= 1'b0;
      status_sel <= 1'b0;
      shreg <= `WORD_RESET;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (addr_last) begin
      // snapshot now so the word holds still while it shifts out; a later event is cleared unread by read_done
      talking <= talk;
      status_sel <= talk && next_hdr[4:0] == `REG_STATUS;
      shreg <= read_word(next_hdr[4:0]);
    end else if (mdc_rise && talking) begin
      if (state == phy_regs_pkg::ST_TA && bit_cnt == 5'h00) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end else if (state == phy_regs_pkg::ST_TA ||
                   (state == phy_regs_pkg::ST_DATA && bit_cnt != `DATA_BITS_LAST)) begin
        mdio_out <= shreg[15];
        shreg <= {shreg[14:0], 1'b0};
      end else if (state == phy_regs_pkg::ST_DATA) begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
        talking <= 1'b0;
      end
    end
  end

  // clear pulse follows the last data bit of a status read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_done <= 1'b0;
    end else begin
      read_done <= mdc_rise && talking && status_sel &&
                   state == phy_regs_pkg::ST_DATA && bit_cnt == `DATA_BITS_LAST;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_t4_bit_zero: assert property (status_word[15] == 1'b0)
    else $error("four-pair capability bit not zero");

  a_speed_caps_set: assert property (status_word[14:11] == 4'hF)
    else $error("speed capability bits not all one");

  a_reserved_zero: assert property (status_word[10:7] == 4'h0)
    else $error("reserved status bits not zero");

  a_preamble_bit_zero: assert property (status_word[6] == 1'b0)
    else $error("preamble suppression bit set");

  a_no_frame_short: assert property (
    (state == phy_regs_pkg::ST_PRE && mdc_rise && !mdio_in && pre_cnt != `PREAMBLE_ONES)
    |=> state == phy_regs_pkg::ST_PRE)
    else $error("frame started without full preamble");

  a_an_done_follow: assert property (
    (events.an_done && !phy_soft_reset) |=> status_word[`BIT_AN_DONE])
    else $error("completion bit did not follow");

  a_fault_sets: assert property (
    events.far_end_fault_flag |=> status_word[`BIT_FAR_FAULT])
    else $error("fault flag not latched");

  a_fault_holds: assert property (
    (fault_q && !read_done) |=> fault_q)
    else $error("fault latch dropped without read");

  a_link_drops: assert property (!events.link_up |=> !status_word[`BIT_LINK])
    else $error("link bit not cleared on failure");

  a_link_stays_low: assert property (
    (!link_q && !read_done) |=> !link_q)
    else $error("link bit recovered without read");

  a_jabber_holds: assert property (
    (jab_q && !read_done && !phy_soft_reset) |=> jab_q)
    else $error("jabber latch dropped early");

  a_jabber_fast_off: assert property (
    (!jab_q && events.speed_100) |=> !jab_q)
    else $error("jabber set at 100 Mb/s");

  a_fixed_low_bits: assert property (status_word[3] && status_word[0])
    else $error("ability or extended bit not one");

  a_id_upper_map: assert property (ids.upper == ORG_ID[21:6])
    else $error("upper identifier mismatch");

  sequence s_status_pick;
    addr_last && talk && next_hdr[4:0] == `REG_STATUS;
  endsequence

  a_status_snapshot: assert property (
    s_status_pick |=> shreg == $past(status_word))
    else $error("status word not captured");

  sequence s_ta_begin;
    mdc_rise && talking && state == phy_regs_pkg::ST_TA && bit_cnt == 5'h00;
  endsequence

  a_ta_drive_zero: assert property (s_ta_begin |=> mdio_oe && !mdio_out)
    else $error("turnaround zero not driven");

  a_clear_after_read: assert property (
    read_done |-> !mdio_oe && $past(mdio_oe))
    else $error("clear pulse not at end of read");

endmodule // phy_status_and_id_regs

`default_nettype wire

// ===== dv/mgmt_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// station manager: one bit per mdc period of 6 core_clk cycles
module mgmt_master_model (
  input wire logic core_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output var logic mdc,
  output logic mdio_in
);
  logic m_drive;
  logic m_bit;
  logic s_out;
  logic s_oe;

  // released line floats high through the pull-up
  assign mdio_in = mdio_oe ? mdio_out : (m_drive ? m_bit : 1'b1);

  initial begin
    mdc = 1'b0;
    m_drive = 1'b0;
    m_bit = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // the phy answer is sampled just before the rise that ends its bit
  task automatic send(input logic en, input logic b);
    @(negedge core_clk);
    mdc = 1'b0;
    m_drive = en;
    m_bit = b;
    repeat (2) @(negedge core_clk);
    s_out = mdio_out;
    s_oe = mdio_oe;
    @(negedge core_clk);
    mdc = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic drove);
    logic [13:0] hdr;
    hdr = {2'b01, op, pa, ra};
    drove = 1'b0;
    rd = 16'h0000;
    for (int i = 0; i < pre; i++) send(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) send(1'b1, hdr[i]);
    for (int i = 17; i >= 0; i--) begin
      send(op == 2'b01, (i > 15) ? (i == 17) : wd[i]);
      if (i < 16) rd[i] = s_out;
      drove = drove | s_oe;
    end
    // driven low so no stray one counts toward the next preamble
    send(1'b1, 1'b0);
  endtask
endmodule // mgmt_master_model

`default_nettype wire

// ===== dv/phy_status_and_id_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module phy_status_and_id_regs_test;
  localparam logic [23:0] ORG = 24'hA5C3E1; // arbitrary value
  localparam logic [5:0] MDL = 6'h2B;       // arbitrary value
  localparam logic [3:0] REV = 4'h9;        // arbitrary value
  localparam logic [4:0] MY_ADDR = 5'h0B;
  logic core_clk;
  logic rst_n;
  logic phy_soft_reset;
  phy_regs_pkg::phy_events_t ev;
  wire logic mdc;
  wire logic mdio_in;
  logic mdio_out;
  logic mdio_oe;
  int n_mismatch;
  int cmp_count;
  logic [15:0] v;
  logic dv;

  phy_status_and_id_regs #(.ORG_ID(ORG), .MODEL(MDL), .REVISION(REV)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .phy_soft_reset(phy_soft_reset), .phy_addr(MY_ADDR),
    .events(ev), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  mgmt_master_model partner_u (
    .core_clk(core_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  function automatic logic [15:0] st(input logic an, input logic f, input logic l, input logic j);
    return {1'h0, 4'hF, 4'h0, 1'h0, an, f, 1'h1, l, j, 1'h1};
  endfunction

  task automatic rd(input logic [4:0] ra);
    partner_u.frame(32, 2'b10, MY_ADDR, ra, 16'h0000, v, dv);
    chk({15'h0000, dv}, 16'h0001);
  endtask

  task automatic soft_rst();
    @(negedge core_clk) phy_soft_reset = 1'b1;
    @(negedge core_clk) phy_soft_reset = 1'b0;
  endtask

  task automatic pulse_fault();
    @(negedge core_clk) ev.far_end_fault_flag = 1'b1;
    @(negedge core_clk) ev.far_end_fault_flag = 1'b0;
  endtask

  task automatic pulse_jab();
    @(negedge core_clk) ev.jabber = 1'b1;
    @(negedge core_clk) ev.jabber = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_fixed();
    rd(5'h01);
    chk(v, st(0, 0, 0, 0));
    rd(5'h02);
    chk(v, ORG[21:6]);
    rd(5'h03);
    chk(v, {ORG[5:0], MDL, REV});
    rd(5'h1F);
    chk(v, 16'h0000);
  endtask

  task automatic t_fault();
    pulse_fault();
    rd(5'h01);
    chk(v, st(0, 1, 0, 0));
    rd(5'h01);
    chk(v, st(0, 0, 0, 0));
    pulse_fault();
    soft_rst();
    rd(5'h01);
    chk(v, st(0, 1, 0, 0));
  endtask

  task automatic t_jabber();
    ev.speed_100 = 1'b1;
    pulse_jab();
    rd(5'h01);
    chk(v, st(0, 0, 0, 0));
    ev.speed_100 = 1'b0;
    pulse_jab();
    rd(5'h01);
    chk(v, st(0, 0, 0, 1));
    rd(5'h01);
    chk(v, st(0, 0, 0, 0));
    pulse_jab();
    soft_rst();
    rd(5'h01);
    chk(v, st(0, 0, 0, 0));
  endtask

  task automatic t_link();
    ev.an_done = 1'b1;
    ev.link_up = 1'b1;
    rd(5'h01);
    chk(v, st(1, 0, 0, 0));
    rd(5'h01);
    chk(v, st(1, 0, 1, 0));
    @(negedge core_clk) ev.link_up = 1'b0;
    @(negedge core_clk) ev.link_up = 1'b1;
    rd(5'h01);
    chk(v, st(1, 0, 0, 0));
    rd(5'h01);
    chk(v, st(1, 0, 1, 0));
  endtask

  task automatic t_refused();
    partner_u.frame(31, 2'b10, MY_ADDR, 5'h01, 16'h0000, v, dv);
    chk({15'h0000, dv}, 16'h0000);
    partner_u.frame(32, 2'b10, MY_ADDR ^ 5'h01, 5'h01, 16'h0000, v, dv);
    chk({15'h0000, dv}, 16'h0000);
    pulse_fault();
    partner_u.frame(32, 2'b01, MY_ADDR, 5'h01, 16'h0000, v, dv);
    chk({15'h0000, dv}, 16'h0000);
    rd(5'h01);
    chk(v, st(1, 1, 1, 0));
  endtask

  // chip reset in mid-run, with mdc left idle high by the last frame
  task automatic t_chip_reset();
    pulse_fault();
    pulse_jab();
    @(negedge core_clk) rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    rd(5'h01);
    chk(v, st(1, 0, 0, 0));
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    phy_soft_reset = 1'b0;
    ev = '0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_fixed();
    t_fault();
    t_jabber();
    t_link();
    t_refused();
    t_chip_reset();
    give_verdict();
  end
endmodule // phy_status_and_id_regs_test

`default_nettype wire
